// ===== acc_pkg.sv
// package for the accessory uart and interrupt register bank
package acc_pkg;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [5:0] ACC_CTRL_BASE = 6'h19;
    localparam logic [5:0] ACC_CTRL_SET = 6'h1a;
    localparam logic [5:0] ACC_CTRL_CLR = 6'h1b;
    localparam logic [5:0] ACC_IEN_BASE = 6'h1d;
    localparam logic [5:0] ACC_IEN_SET = 6'h1e;
    localparam logic [5:0] ACC_IEN_CLR = 6'h1f;
    localparam logic [5:0] ACC_STAT_ADDR = 6'h20;
    localparam logic [5:0] ACC_LATCH_ADDR = 6'h21;

    localparam logic [7:0] ACC_CTRL_MASK = 8'h0e;
    localparam logic [7:0] ACC_IEN_MASK = 8'h23;
    localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
    localparam logic [7:0] ACC_IEN_RESET = 8'h00;
    localparam logic [7:0] ACC_LATCH_RESET = 8'h00;

    localparam int ACC_CTRL_IDGND_BIT = 1;
    localparam int ACC_CTRL_TX_BIT = 2;
    localparam int ACC_CTRL_RX_BIT = 3;
    localparam int ACC_IEN_RISE_BIT = 0;
    localparam int ACC_IEN_FALL_BIT = 1;
    localparam int ACC_IEN_CONV_BIT = 5;
    localparam int ACC_STAT_FLOAT_BIT = 0;
    localparam int ACC_STAT_CODE_LSB = 3;
    localparam int ACC_STAT_DONE_BIT = 6;
    localparam int ACC_LATCH_FLOAT_BIT = 0;
    localparam int ACC_LATCH_CONV_BIT = 3;

    localparam logic [2:0] ACC_CODE_FLOAT = 3'h5;
    localparam logic [2:0] ACC_CODE_ERROR = 3'h7;

    // resistor conversion time
    localparam int ACC_CONV_TIME_NS = 282000;
    localparam int ACC_CLK_PERIOD_NS = 5;
    localparam int ACC_CONV_CYCLES = (ACC_CONV_TIME_NS + ACC_CLK_PERIOD_NS - 1) / ACC_CLK_PERIOD_NS;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } acc_req_type;

    typedef struct packed {
        logic       floating;
        logic [2:0] code;
        logic       done;
    } acc_conv_type;
endpackage : acc_pkg

// ===== acc_edge_latch.sv
// sticky event bit: set on a qualified event, cleared on read, set wins
module acc_edge_latch (
    input  wire logic mclk,     // clock
    input  wire logic rst,      // synchronous reset
    input  wire logic event_in, // qualified event pulse
    input  wire logic clear,    // read of the latch register
    output logic      flag      // sticky flag
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (event_in) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end
endmodule : acc_edge_latch

// ===== acc_uart_irq_regs.sv
// accessory uart routing and id / resistor interrupt register bank
// Function
// - control register reads at three addresses; write, set and clear at each
// - interrupt enable reads at three addresses; write, set and clear at each
// - receive routing off holds data line 1 high
// - control bit 1 drives id pin to ground
// - control bit 2 routes data line 0 transmit data onto dm
// - control bit 3 routes dp receive data onto data line 1
// - unimplemented detection bits and control bit 0 read zero, ignore writes
// - enable bit 0 raises alt_int when id goes floating
// - enable bit 1 raises alt_int when id stops floating
// - status bit 0 shows id pin floating
// - enable bit 5 or vendor enable raises alt_int on conversion done
// - status bits 5:3 report id resistor code
// - status bit 6 sets when conversion finishes, 282 us after start
// - done flag clears only on vendor register code read
// - status register read-only without read side effects
// - latch register read-only, implemented bits clear on read
// - latch bit 0 sets on enabled float rise or fall
// - latch bit 3 sets on enabled done rising edge
module acc_uart_irq_regs
    import acc_pkg::*;
#(
    parameter int CONV_CYCLES = ACC_CONV_CYCLES
) (
    input  wire logic         mclk,             // ulpi clock
    input  wire logic         rst,              // synchronous reset, high
    input  wire acc_req_type  req,              // register access strobe
    output logic       [7:0]  rdata,            // read data, registered
    input  wire logic         id_floating,      // id pin floating detect
    input  wire logic         conv_start,       // vendor conversion start pulse
    input  wire logic  [2:0]  conv_result,      // converter result code
    input  wire logic         vendor_code_read, // vendor register code read
    input  wire logic         vendor_conv_ien,  // vendor conversion irq enable
    input  wire logic         ulpi_data0_in,    // data line 0 input, uart txd
    input  wire logic         dp_rx_in,         // dp line receive level
    output logic              ulpi_data1_out,   // data line 1 output
    output logic              dm_tx_out,        // dm line drive value
    output logic              dm_tx_oe,         // dm line drive enable
    output logic              id_gnd_oe,        // id pin pulled to ground
    output logic              uart_tx_route_en, // tx routing enable
    output logic              uart_rx_route_en, // rx routing enable
    output logic              conv_busy,        // conversion in progress
    output acc_conv_type      conv_state,       // converter state view
    output logic              alt_int           // alt_int event pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  accessory_uart_control;
    logic [7:0]  accessory_irq_enable;
    logic [7:0]  accessory_irq_status;
    logic [7:0]  accessory_irq_latch;
    logic        id_float_event_latched;
    logic        resistor_conv_event_latched;
    logic        id_floating_status;
    logic [2:0]  id_resistor_code;
    logic        resistor_conv_done;
    logic        float_prev;
    logic        done_prev;
    logic [31:0] conv_count;
    logic        float_rise_evt;
    logic        float_fall_evt;
    logic        float_evt;
    logic        conv_evt;
    logic        conv_ien_eff;
    logic        latch_read;
    logic [7:0]  next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // control register, write / set / clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            accessory_uart_control <= ACC_CTRL_RESET;
        end else if (req.wr) begin
            unique case (req.addr)
                ACC_CTRL_BASE: accessory_uart_control <= req.wdata & ACC_CTRL_MASK;
                ACC_CTRL_SET:  accessory_uart_control <= (accessory_uart_control | req.wdata) & ACC_CTRL_MASK;
                ACC_CTRL_CLR:  accessory_uart_control <= accessory_uart_control & ~req.wdata & ACC_CTRL_MASK;
                default: ;
            endcase
        end
    end

    // interrupt enable register, write / set / clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            accessory_irq_enable <= ACC_IEN_RESET;
        end else if (req.wr) begin
            unique case (req.addr)
                ACC_IEN_BASE: accessory_irq_enable <= req.wdata & ACC_IEN_MASK;
                ACC_IEN_SET:  accessory_irq_enable <= (accessory_irq_enable | req.wdata) & ACC_IEN_MASK;
                ACC_IEN_CLR:  accessory_irq_enable <= accessory_irq_enable & ~req.wdata & ACC_IEN_MASK;
                default: ;
            endcase
        end
    end

    assign uart_tx_route_en = accessory_uart_control[ACC_CTRL_TX_BIT];
    assign uart_rx_route_en = accessory_uart_control[ACC_CTRL_RX_BIT];
    assign id_gnd_oe        = accessory_uart_control[ACC_CTRL_IDGND_BIT];

    ////////////////////////////////////////////////////////////////////////
    // uart routing; mode select lives in the interface control block
    always_ff @(posedge mclk) begin
        if (rst) begin
            ulpi_data1_out <= 1'b1;
            dm_tx_out      <= 1'b0;
            dm_tx_oe       <= 1'b0;
        end else begin
            ulpi_data1_out <= uart_rx_route_en ? dp_rx_in : 1'b1;
            dm_tx_out      <= uart_tx_route_en & ulpi_data0_in;
            dm_tx_oe       <= uart_tx_route_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // id float sampling and resistor conversion timer
    always_ff @(posedge mclk) begin
        if (rst) begin
            id_floating_status <= 1'b0;
            float_prev         <= 1'b0;
        end else begin
            id_floating_status <= id_floating;
            float_prev         <= id_floating_status;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            conv_busy        <= 1'b0;
            conv_count       <= 32'h0;
            id_resistor_code <= 3'h0;
        end else if (conv_busy) begin
            if (conv_count == 32'(CONV_CYCLES - 1)) begin
                conv_busy        <= 1'b0;
                id_resistor_code <= conv_result;
            end
            conv_count <= conv_count + 32'h1;
        end else if (conv_start) begin
            conv_busy  <= 1'b1;
            conv_count <= 32'h0;
        end
    end

    // done sets on completion, set wins over vendor read clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            resistor_conv_done <= 1'b0;
            done_prev          <= 1'b0;
        end else begin
            done_prev <= resistor_conv_done;
            if (conv_busy && conv_count == 32'(CONV_CYCLES - 1)) begin
                resistor_conv_done <= 1'b1;
            end else if (vendor_code_read) begin
                resistor_conv_done <= 1'b0;
            end
        end
    end

    assign conv_state = '{floating: id_floating_status, code: id_resistor_code, done: resistor_conv_done};

    ////////////////////////////////////////////////////////////////////////
    // events and latches
    assign conv_ien_eff   = accessory_irq_enable[ACC_IEN_CONV_BIT] | vendor_conv_ien;
    assign float_rise_evt = id_floating_status & ~float_prev & accessory_irq_enable[ACC_IEN_RISE_BIT];
    assign float_fall_evt = ~id_floating_status & float_prev & accessory_irq_enable[ACC_IEN_FALL_BIT];
    assign float_evt      = float_rise_evt | float_fall_evt;
    assign conv_evt       = resistor_conv_done & ~done_prev & conv_ien_eff;
    assign latch_read     = req.rd && (req.addr == ACC_LATCH_ADDR);

    acc_edge_latch u_float_latch (
        .mclk     (mclk),
        .rst      (rst),
        .event_in (float_evt),
        .clear    (latch_read),
        .flag     (id_float_event_latched)
    );

    acc_edge_latch u_conv_latch (
        .mclk     (mclk),
        .rst      (rst),
        .event_in (conv_evt),
        .clear    (latch_read),
        .flag     (resistor_conv_event_latched)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            alt_int <= 1'b0;
        end else begin
            alt_int <= float_evt | conv_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path; status has no read side effect
    always_comb begin
        accessory_irq_status = 8'h00;
        accessory_irq_status[ACC_STAT_FLOAT_BIT] = id_floating_status;
        accessory_irq_status[ACC_STAT_CODE_LSB +: 3] = id_resistor_code;
        accessory_irq_status[ACC_STAT_DONE_BIT] = resistor_conv_done;
        accessory_irq_latch = ACC_LATCH_RESET;
        accessory_irq_latch[ACC_LATCH_FLOAT_BIT] = id_float_event_latched;
        accessory_irq_latch[ACC_LATCH_CONV_BIT] = resistor_conv_event_latched;
    end

    always_comb begin
        unique case (req.addr)
            ACC_CTRL_BASE, ACC_CTRL_SET, ACC_CTRL_CLR: next_rdata = accessory_uart_control;
            ACC_IEN_BASE, ACC_IEN_SET, ACC_IEN_CLR:    next_rdata = accessory_irq_enable;
            ACC_STAT_ADDR:                             next_rdata = accessory_irq_status;
            ACC_LATCH_ADDR:                            next_rdata = accessory_irq_latch;
            default:                                   next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            rdata <= next_rdata;
        end
    end
endmodule : acc_uart_irq_regs

// ===== acc_link_model.sv
// link controller model issuing register reads and writes
module acc_link_model
    import acc_pkg::*;
(
    input  wire logic        mclk,  // clock
    input  wire logic [7:0]  rdata, // read data
    output acc_req_type      req    // request strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial req = '0;
    // routing enables are written before any serial mode select
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        req <= '0;
        #1;
        d = rdata;
    endtask : rd
endmodule : acc_link_model

// ===== acc_uart_irq_regs_assertions.sv
// concurrent checks on the accessory register bank ports
module acc_uart_irq_chk
    import acc_pkg::*;
#(
    parameter int CONV_CYCLES = ACC_CONV_CYCLES
) (
    input wire logic        mclk,             // clock
    input wire logic        rst,              // reset
    input wire acc_req_type req,              // request
    input wire logic        id_floating,      // float detect
    input wire logic        conv_start,       // start pulse
    input wire logic        vendor_code_read, // vendor read
    input wire logic        ulpi_data0_in,    // txd
    input wire logic        dp_rx_in,         // dp level
    input wire logic        ulpi_data1_out,   // rxd out
    input wire logic        dm_tx_out,        // dm value
    input wire logic        dm_tx_oe,         // dm enable
    input wire logic        id_gnd_oe,        // id ground
    input wire logic        uart_tx_route_en, // tx route
    input wire logic        uart_rx_route_en, // rx route
    input wire logic        conv_busy,        // busy
    input wire acc_conv_type conv_state,      // converter view
    input wire logic        alt_int           // event pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] busy_len;
    // length of the current busy stretch, for the conversion time check
    always_ff @(posedge mclk) begin
        if (rst || !conv_busy) begin
            busy_len <= 32'h0;
        end else begin
            busy_len <= busy_len + 32'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_rx_idle_high: assert property (!uart_rx_route_en |=> ulpi_data1_out)
        else $error("data line 1 not high with rx routing off");
    chk_rx_route_data: assert property (uart_rx_route_en |=> ulpi_data1_out == $past(dp_rx_in))
        else $error("rx data not routed");
    chk_tx_route_data: assert property (1'b1 |=> dm_tx_oe == $past(uart_tx_route_en)
        && dm_tx_out == $past(ulpi_data0_in && uart_tx_route_en)) else $error("tx data not routed");
    chk_ctrl_write: assert property (req.wr && req.addr == ACC_CTRL_BASE
        |=> {uart_rx_route_en, uart_tx_route_en, id_gnd_oe} == $past(req.wdata[3:1])) else $error("ctrl write lost");
    chk_ctrl_clear: assert property (req.wr && req.addr == ACC_CTRL_CLR
        |=> ({uart_rx_route_en, uart_tx_route_en, id_gnd_oe} & $past(req.wdata[3:1])) == 3'h0) else $error("ctrl clear");
    chk_float_status: assert property (1'b1 |=> conv_state.floating == $past(id_floating))
        else $error("float status wrong");
    chk_irq_cause: assert property (alt_int
        |-> $past(conv_state.floating) != $past(conv_state.floating, 2)
        || ($past(conv_state.done) && !$past(conv_state.done, 2))) else $error("alt_int without cause");
    chk_done_sticky: assert property (conv_state.done && !vendor_code_read |=> conv_state.done)
        else $error("done flag cleared without vendor read");
    chk_conv_time: assert property ($fell(conv_busy)
        |-> busy_len == 32'(CONV_CYCLES) && conv_state.done) else $error("conversion time wrong");
endmodule : acc_uart_irq_chk
bind acc_uart_irq_regs acc_uart_irq_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .mclk(mclk), .rst(rst), .req(req), .id_floating(id_floating), .conv_start(conv_start),
    .vendor_code_read(vendor_code_read), .ulpi_data0_in(ulpi_data0_in), .dp_rx_in(dp_rx_in),
    .ulpi_data1_out(ulpi_data1_out), .dm_tx_out(dm_tx_out), .dm_tx_oe(dm_tx_oe), .id_gnd_oe(id_gnd_oe),
    .uart_tx_route_en(uart_tx_route_en), .uart_rx_route_en(uart_rx_route_en), .conv_busy(conv_busy),
    .conv_state(conv_state), .alt_int(alt_int)
);

// ===== tb.sv
// testbench for the accessory uart and interrupt register bank
module tb
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CONV = 8;
    logic mclk = 1'b0, rst = 1'b1, id_floating = 1'b0, conv_start = 1'b0, vendor_code_read = 1'b0;
    logic vendor_conv_ien = 1'b0, data0 = 1'b0, dp_rx = 1'b0, data1, dm_out, dm_oe, id_gnd, tx_en, rx_en, busy, alt_int;
    logic [2:0] conv_result = 3'h0;
    logic [7:0] rdata, rv;
    acc_req_type req;
    acc_conv_type conv_state;
    int failures = 0, comparisons = 0, alt_count = 0, n, x;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (alt_int === 1'b1) alt_count <= alt_count + 1;
    acc_link_model link (.mclk(mclk), .rdata(rdata), .req(req));
    acc_uart_irq_regs #(.CONV_CYCLES(CONV)) dut (
        .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .id_floating(id_floating), .conv_start(conv_start),
        .conv_result(conv_result), .vendor_code_read(vendor_code_read), .vendor_conv_ien(vendor_conv_ien),
        .ulpi_data0_in(data0), .dp_rx_in(dp_rx), .ulpi_data1_out(data1), .dm_tx_out(dm_out), .dm_tx_oe(dm_oe),
        .id_gnd_oe(id_gnd), .uart_tx_route_en(tx_en), .uart_rx_route_en(rx_en), .conv_busy(busy),
        .conv_state(conv_state), .alt_int(alt_int)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        link.rd(a, rv);
        chk($sformatf("reg %h", a), exp, rv);
    endtask : rchk
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick
    // one conversion; irq enable from bank bit or vendor bit
    task automatic conv(input logic ien, input logic ven, input logic [2:0] code);
        int m;
        m = alt_count;
        link.wr(ACC_IEN_BASE, {2'b00, ien, 5'h00});
        @(posedge mclk) begin
            vendor_conv_ien <= ven;
            conv_result <= code;
            conv_start <= 1'b1;
        end
        @(posedge mclk) conv_start <= 1'b0;
        #1 chk("busy", 8'h01, {7'h00, busy});
        tick(CONV + 4);
        chk("busy", 8'h00, {7'h00, busy});
        rchk(ACC_STAT_ADDR, {2'b01, code, 3'b000});
        rchk(ACC_STAT_ADDR, {2'b01, code, 3'b000});
        rchk(ACC_LATCH_ADDR, {4'h0, ien | ven, 3'b000});
        chk("alt_int count", {7'h00, ien | ven}, 8'(alt_count - m));
        @(posedge mclk) vendor_code_read <= 1'b1;
        @(posedge mclk) vendor_code_read <= 1'b0;
        rchk(ACC_STAT_ADDR, {2'b00, code, 3'b000});
    endtask : conv
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rchk(6'h19 + 6'(i), 8'h00);
        link.wr(ACC_CTRL_BASE, 8'hff);
        for (int i = 0; i < 3; i++) rchk(ACC_CTRL_BASE + 6'(i), 8'h0e);
        chk("id ground", 8'h01, {7'h00, id_gnd});
        link.wr(ACC_CTRL_CLR, 8'h03);
        rchk(ACC_CTRL_SET, 8'h0c);
        link.wr(ACC_CTRL_SET, 8'h01);
        rchk(ACC_CTRL_CLR, 8'h0c);
        @(posedge mclk) data0 <= 1'b1;
        tick(2);
        chk("routes", 8'h0c, {4'h0, dm_out, dm_oe, data1, id_gnd});
        @(posedge mclk) begin
            data0 <= 1'b0;
            dp_rx <= 1'b1;
        end
        tick(2);
        chk("routes", 8'h06, {4'h0, dm_out, dm_oe, data1, id_gnd});
        link.wr(ACC_CTRL_CLR, 8'h08);
        @(posedge mclk) dp_rx <= 1'b0;
        tick(2);
        chk("rx idle", 8'h06, {4'h0, dm_out, dm_oe, data1, id_gnd});
        link.wr(ACC_IEN_BASE, 8'hff);
        rchk(ACC_IEN_SET, 8'h23);
        link.wr(ACC_IEN_CLR, 8'h22);
        rchk(ACC_IEN_CLR, 8'h01);
        link.wr(ACC_IEN_SET, 8'h02);
        rchk(ACC_IEN_BASE, 8'h03);
        // float detect is driven as if the id pull-up were on
        for (int e = 3; e >= 0; e--) begin
            link.wr(ACC_IEN_BASE, 8'(e));
            for (int f = 1; f >= 0; f--) begin
                n = alt_count;
                @(posedge mclk) id_floating <= f[0];
                tick(4);
                rchk(ACC_STAT_ADDR, 8'(f));
                x = (f == 1) ? (e & 1) : ((e >> 1) & 1);
                rchk(ACC_LATCH_ADDR, 8'(x));
                chk("alt_int count", 8'(x), 8'(alt_count - n));
            end
            rchk(ACC_LATCH_ADDR, 8'h00);
        end
        for (int c = 0; c < 8; c++) if (c != 6) conv(c[0], c[1], 3'(c));
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        wrap_up();
    end
endmodule : tb
